// ### rtl/nxs_cfg.svh
`ifndef NXS_CFG_SVH
`define NXS_CFG_SVH
// ==========================================
// opcode matching, value after mask
`define NXS_M_SUBI   13'h1fd0
`define NXS_V_SUBI   13'h1810
`define NXS_M_TST    13'h1e00
`define NXS_V_TST    13'h1200
`define NXS_M_XRR    13'h1ff0
`define NXS_V_XRR    13'h1bf0
`define NXS_M_XRI    13'h1fe0
`define NXS_V_XRI    13'h1bc0
`define NXS_V_XFI    13'h10a0
`define NXS_V_XRM    13'h1be0
`define NXS_M_XMI    13'h1fc0
`define NXS_V_XMI    13'h1b80
// ==========================================
// pages for extended and short absolute access
`define NXS_PAGE_X   8'h00
`define NXS_PAGE_Y   8'hff
`define NXS_TST_LO   10'h000
`define NXS_TST_HI   10'h3ff
// ==========================================
// flag register bit positions
`define NXS_F_E      3
`define NXS_F_I      2
`define NXS_F_C      1
`define NXS_F_Z      0
// ==========================================
// register byte offsets and reset values
`define NXS_R_OPCODE 8'h00
`define NXS_R_STATUS 8'h04
`define NXS_R_DATA   8'h08
`define NXS_R_PTR    8'h0c
`define NXS_R_PREFIX 8'h10
`define NXS_RST_NIB  4'h0
`define NXS_RST_PTR  16'h0000
`define NXS_RST_PFX  8'h00
// ==========================================
// clocks per core cycle
`define NXS_CLK_PER_CYC 3'h2
`endif

// ### rtl/nxs_pkg.sv
package nxs_pkg;
  typedef enum logic [8:0] {
    NXS_K_SUBI = 9'h001,
    NXS_K_TST  = 9'h002,
    NXS_K_XRR  = 9'h004,
    NXS_K_XRI  = 9'h008,
    NXS_K_XFI  = 9'h010,
    NXS_K_XRM  = 9'h020,
    NXS_K_XMR  = 9'h040,
    NXS_K_XMI  = 9'h080,
    NXS_K_BAD  = 9'h100
  } nxs_kind_t;
  typedef enum logic [3:0] {
    NXS_S_IDLE = 4'h1,
    NXS_S_READ = 4'h2,
    NXS_S_EXEC = 4'h4,
    NXS_S_TAIL = 4'h8
  } nxs_state_t;
  typedef struct packed {
    nxs_kind_t  kind;
    logic       ptr_y;
    logic       dst_b;
    logic       src_b;
    logic       post_inc;
    logic       ext_ok;
    logic       two_cyc;
  } nxs_dec_t;
endpackage : nxs_pkg

// ### rtl/nxs_exec.sv
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "nxs_cfg.svh"
// How it works
// - subtract a literal from the pointed nibble, store it back, then bump the pointer.
// - post-increment forms set flags from the stored result only, never from the bump.
// - the bit probe takes one cycle, sets Z from the chosen bit and never writes memory.
// - register-register XOR stores into the destination, opcode bit 0 ignored.
// - register-literal XOR stores into the register chosen by opcode bit 4.
// - literal XOR into the flag register takes one cycle and may flip any flag.
// - XOR of a pointed nibble into a register stores in the register, prefix allowed.
// - after a prefix load, pointer X reaches 0000H plus it and pointer Y FF00H plus it.
// - register-from-memory XOR with bump takes one cycle and then bumps the pointer.
// - XOR of a register into a pointed nibble writes it back, prefix allowed.
// - the bumping register-into-memory XOR takes two cycles, writes, then bumps.
// - literal XOR into a pointed nibble takes two cycles and writes back.
// - the bumping literal-into-memory XOR takes two cycles, writes, then bumps.
// - XOR forms other than the flag one clear E, keep I and C and update Z.
// - bumping, register-only, literal-to-register forms and the probe ignore the prefix.
module nxs_exec #(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk_sys_i,
  input  wire logic              arst_n_i,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [15:0]            mem_addr_o,
  output logic                   mem_re_o,
  output logic                   mem_we_o,
  output logic [3:0]             mem_wdata_o,
  input  wire logic [3:0]        mem_rdata_i,
  output logic                   done_o
);
  import nxs_pkg::*;

  // ==========================================
  // decode
  function automatic nxs_dec_t decode(input logic [12:0] op);
    nxs_dec_t d;
    d = '{kind: NXS_K_BAD, ptr_y: 1'b0, dst_b: 1'b0, src_b: 1'b0,
          post_inc: 1'b0, ext_ok: 1'b0, two_cyc: 1'b0};
    if ((op & `NXS_M_SUBI) == `NXS_V_SUBI)
    begin
      d.kind = NXS_K_SUBI;
      d.ptr_y = op[5];
      d.post_inc = 1'b1;
      d.two_cyc = 1'b1;
    end
    else if ((op & `NXS_M_TST) == `NXS_V_TST)
      d.kind = NXS_K_TST;
    else if ((op & `NXS_M_XRR) == `NXS_V_XRR)
    begin
      d.kind = NXS_K_XRR;
      d.dst_b = op[2];
      d.src_b = op[1];
    end
    else if ((op & `NXS_M_XRI) == `NXS_V_XRI)
    begin
      d.kind = NXS_K_XRI;
      d.dst_b = op[4];
    end
    else if ((op & `NXS_M_XRR) == `NXS_V_XFI)
      d.kind = NXS_K_XFI;
    else if ((op & `NXS_M_XRR) == `NXS_V_XRM)
    begin
      d.kind = op[3] ? NXS_K_XMR : NXS_K_XRM;
      d.dst_b = op[2];
      d.ptr_y = op[1];
      d.post_inc = op[0];
      d.ext_ok = ~op[0];
      d.two_cyc = op[3];
    end
    else if ((op & `NXS_M_XMI) == `NXS_V_XMI)
    begin
      d.kind = NXS_K_XMI;
      d.ptr_y = op[5];
      d.post_inc = op[4];
      d.ext_ok = ~op[4];
      d.two_cyc = 1'b1;
    end
    return d;
  endfunction : decode

  // ==========================================
  // state
  nxs_state_t  state;
  nxs_dec_t    cur;
  logic [12:0] opc;
  logic [2:0]  clk_cnt;
  logic [3:0]  reg_a;
  logic [3:0]  reg_b;
  logic [3:0]  reg_f;
  logic [15:0] ptr_x;
  logic [15:0] ptr_y;
  logic [7:0]  address_prefix_register;
  logic        bad_op;
  logic        aw_got;
  logic        w_got;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  nxs_dec_t    next_dec;
  logic        launch;
  logic        wr_fire;
  logic        last_clk;
  logic        bump_now;
  logic [3:0]  nibble_literal;
  logic [1:0]  bit_index_literal;
  logic [5:0]  short_absolute_field;
  logic        pointer_select;
  logic [3:0]  src_nib;
  logic [3:0]  dst_nib;
  logic [3:0]  xor_res;
  logic [4:0]  sub_res;
  logic        probe_bit;

  assign wr_fire = aw_got && w_got && !s_axi_bvalid;
  assign launch = wr_fire && state == NXS_S_IDLE && aw_addr == `NXS_R_OPCODE && w_strb[0];
  assign next_dec = decode(w_data[12:0]);
  assign nibble_literal = opc[3:0];
  assign bit_index_literal = opc[7:6];
  assign short_absolute_field = opc[5:0];
  assign pointer_select = cur.ptr_y;
  // a one-cycle op finishes at the end of the exec clock, a two-cycle op two clocks later
  assign last_clk = (state == NXS_S_EXEC && !cur.two_cyc) ||
                    (state == NXS_S_TAIL && clk_cnt == (`NXS_CLK_PER_CYC << 1) - 3'h1);
  assign bump_now = last_clk && cur.post_inc;
  assign src_nib = cur.src_b ? reg_b : reg_a;
  assign dst_nib = cur.dst_b ? reg_b : reg_a;
  assign probe_bit = mem_rdata_i[bit_index_literal];

  always_comb
  begin
    xor_res = 4'h0;
    sub_res = {1'b0, mem_rdata_i} - {1'b0, nibble_literal};
    case (cur.kind)
      NXS_K_XRR: xor_res = dst_nib ^ src_nib;
      NXS_K_XRI: xor_res = dst_nib ^ nibble_literal;
      NXS_K_XRM: xor_res = dst_nib ^ mem_rdata_i;
      NXS_K_XMR: xor_res = mem_rdata_i ^ dst_nib;
      NXS_K_XMI: xor_res = mem_rdata_i ^ nibble_literal;
      default:   xor_res = 4'h0;
    endcase
  end

  // ==========================================
  // sequencer and memory port
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state <= NXS_S_IDLE;
      cur <= '{kind: NXS_K_BAD, ptr_y: 1'b0, dst_b: 1'b0, src_b: 1'b0,
               post_inc: 1'b0, ext_ok: 1'b0, two_cyc: 1'b0};
      opc <= 13'h0000;
      clk_cnt <= 3'h0;
      mem_addr_o <= `NXS_RST_PTR;
      mem_re_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_wdata_o <= `NXS_RST_NIB;
      done_o <= 1'b0;
      bad_op <= 1'b0;
    end
    else
    begin
      done_o <= last_clk;
      mem_re_o <= 1'b0;
      mem_we_o <= 1'b0;
      clk_cnt <= clk_cnt + 3'h1;
      case (state)
        NXS_S_IDLE:
          if (launch)
          begin
            cur <= next_dec;
            opc <= w_data[12:0];
            clk_cnt <= 3'h0;
            bad_op <= next_dec.kind == NXS_K_BAD;
            if (next_dec.kind == NXS_K_TST)
              mem_addr_o <= w_data[8] ? {`NXS_TST_HI, w_data[5:0]}
                                      : {`NXS_TST_LO, w_data[5:0]};
            else if (next_dec.ext_ok && reg_f[`NXS_F_E])
              mem_addr_o <= {next_dec.ptr_y ? `NXS_PAGE_Y : `NXS_PAGE_X,
                             address_prefix_register};
            else
              mem_addr_o <= next_dec.ptr_y ? ptr_y : ptr_x;
            mem_re_o <= next_dec.kind inside {NXS_K_SUBI, NXS_K_TST, NXS_K_XRM,
                                              NXS_K_XMR, NXS_K_XMI};
            state <= next_dec.kind == NXS_K_BAD ? NXS_S_IDLE : NXS_S_READ;
          end
        NXS_S_READ:
          state <= NXS_S_EXEC;
        NXS_S_EXEC:
        begin
          // write-back keeps the pre-bump address latched in mem_addr_o
          if (cur.kind inside {NXS_K_SUBI, NXS_K_XMR, NXS_K_XMI})
          begin
            mem_we_o <= 1'b1;
            mem_wdata_o <= cur.kind == NXS_K_SUBI ? sub_res[3:0] : xor_res;
          end
          state <= cur.two_cyc ? NXS_S_TAIL : NXS_S_IDLE;
        end
        NXS_S_TAIL:
          if (last_clk)
            state <= NXS_S_IDLE;
        default:
          state <= NXS_S_IDLE;
      endcase
    end
  end

  // ==========================================
  // architectural registers
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      reg_a <= `NXS_RST_NIB;
      reg_b <= `NXS_RST_NIB;
      reg_f <= `NXS_RST_NIB;
      ptr_x <= `NXS_RST_PTR;
      ptr_y <= `NXS_RST_PTR;
      address_prefix_register <= `NXS_RST_PFX;
    end
    else
    begin
      // software writes only land while idle, so they never race the datapath
      if (wr_fire && state == NXS_S_IDLE)
      begin
        if (aw_addr == `NXS_R_DATA && w_strb[0])
          {reg_b, reg_a} <= w_data[7:0];
        if (aw_addr == `NXS_R_DATA && w_strb[1])
          reg_f <= w_data[11:8];
        if (aw_addr == `NXS_R_PTR)
        begin
          if (w_strb[0]) ptr_x[7:0] <= w_data[7:0];
          if (w_strb[1]) ptr_x[15:8] <= w_data[15:8];
          if (w_strb[2]) ptr_y[7:0] <= w_data[23:16];
          if (w_strb[3]) ptr_y[15:8] <= w_data[31:24];
        end
        if (aw_addr == `NXS_R_PREFIX && w_strb[0])
        begin
          address_prefix_register <= w_data[7:0]; // a write to the prefix register arms the prefix
          reg_f[`NXS_F_E] <= 1'b1;
        end
      end
      if (state == NXS_S_EXEC)
      begin
        case (cur.kind)
          NXS_K_SUBI:
          begin
            reg_f[`NXS_F_E] <= 1'b0;
            reg_f[`NXS_F_C] <= sub_res[4];
            reg_f[`NXS_F_Z] <= sub_res[3:0] == 4'h0;
          end
          NXS_K_TST:
          begin
            reg_f[`NXS_F_E] <= 1'b0;
            reg_f[`NXS_F_Z] <= ~probe_bit;
          end
          NXS_K_XFI:
            reg_f <= reg_f ^ nibble_literal;
          NXS_K_XRR, NXS_K_XRI, NXS_K_XRM:
          begin
            if (cur.dst_b) reg_b <= xor_res;
            else reg_a <= xor_res;
            reg_f[`NXS_F_E] <= 1'b0;
            reg_f[`NXS_F_Z] <= xor_res == 4'h0;
          end
          NXS_K_XMR, NXS_K_XMI:
          begin
            reg_f[`NXS_F_E] <= 1'b0;
            reg_f[`NXS_F_Z] <= xor_res == 4'h0;
          end
          default:
            reg_f <= reg_f;
        endcase
      end
      // the bump touches only the pointer, never a flag
      if (bump_now && pointer_select)
        ptr_y <= ptr_y + 16'h0001;
      else if (bump_now)
        ptr_x <= ptr_x + 16'h0001;
    end
  end

  // ==========================================
  // register bus slave
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // unmapped answers SLVERR; a write while busy is dropped but acknowledged
        s_axi_bresp <= aw_addr inside {`NXS_R_OPCODE, `NXS_R_STATUS, `NXS_R_DATA,
                                       `NXS_R_PTR, `NXS_R_PREFIX} ? 2'h0 : 2'h2;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      if (s_axi_araddr == `NXS_R_OPCODE)
        s_axi_rdata <= {19'h0, opc};
      else if (s_axi_araddr == `NXS_R_STATUS)
        s_axi_rdata <= {30'h0, bad_op, state != NXS_S_IDLE};
      else if (s_axi_araddr == `NXS_R_DATA)
        s_axi_rdata <= {20'h0, reg_f, reg_b, reg_a};
      else if (s_axi_araddr == `NXS_R_PTR)
        s_axi_rdata <= {ptr_y, ptr_x};
      else if (s_axi_araddr == `NXS_R_PREFIX)
        s_axi_rdata <= {24'h0, address_prefix_register};
      else
      begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= 2'h2;
      end
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================
  // checks
  a_one_cyc_done: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    launch && !next_dec.two_cyc && next_dec.kind != NXS_K_BAD |-> ##3 done_o)
    else $error("one-cycle op did not finish in two clocks");
  a_two_cyc_done: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    launch && next_dec.two_cyc |-> !done_o [*5] ##1 done_o)
    else $error("two-cycle op did not finish in four clocks");
  a_bump_flags: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    bump_now && cur.two_cyc |=> $stable(reg_f))
    else $error("pointer bump changed a flag");
  a_xor_clear_e: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    state == NXS_S_EXEC && cur.kind inside {NXS_K_XRR, NXS_K_XRI, NXS_K_XRM,
                                            NXS_K_XMR, NXS_K_XMI}
    |=> !reg_f[`NXS_F_E] && reg_f[`NXS_F_Z] == ($past(xor_res) == 4'h0))
    else $error("xor left E set or Z wrong");
  a_ext_page_y: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    launch && next_dec.ext_ok && next_dec.ptr_y && reg_f[`NXS_F_E]
    |=> mem_addr_o == {`NXS_PAGE_Y, address_prefix_register})
    else $error("prefixed Y access off page");
  a_post_no_ext: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    launch && next_dec.post_inc && !next_dec.ptr_y |=> mem_addr_o == $past(ptr_x))
    else $error("bumping form used the prefix");
  a_probe_no_wr: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    state != NXS_S_IDLE && cur.kind == NXS_K_TST |-> !mem_we_o)
    else $error("probe wrote memory");
  a_bump_wrap: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    bump_now && !pointer_select |=> ptr_x == $past(ptr_x) + 16'h0001)
    else $error("pointer bump wrong");
  a_wr_pre_addr: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    mem_we_o && cur.post_inc |-> mem_addr_o == (cur.ptr_y ? ptr_y : ptr_x))
    else $error("write used bumped address");
endmodule : nxs_exec

// ### bench/nxs_mem_model.sv
`timescale 1ns/1ps
// ==========================================
// nibble data memory, synchronous read one clock after the request
module nxs_mem_model (
  input  wire logic        clk_sys_i,
  input  wire logic [15:0] mem_addr_i,
  input  wire logic        mem_re_i,
  input  wire logic        mem_we_i,
  input  wire logic [3:0]  mem_wdata_i,
  output logic [3:0]       mem_rdata_o
);
  logic [3:0] mem [0:65535];

  initial
  begin
    foreach (mem[i]) mem[i] = 4'h0;
    mem_rdata_o = 4'h0;
  end

  // outside the answer clock the data toggles, so a late sample cannot match by luck
  always @(posedge clk_sys_i)
  begin
    if (mem_we_i)
      mem[mem_addr_i] <= mem_wdata_i;
    if (mem_re_i)
      mem_rdata_o <= mem[mem_addr_i];
    else
      mem_rdata_o <= ~mem_rdata_o;
  end
endmodule : nxs_mem_model

// ### bench/nxs_exec_test.sv
`timescale 1ns/1ps
module nxs_exec_test;
  import nxs_pkg::*;
  // ==========================================
  // signals
  logic        clk_sys_i = 1'b0;
  logic        arst_n_i  = 1'b0;
  logic [7:0]  awaddr    = 8'h00;
  logic        awvalid   = 1'b0;
  logic [31:0] wdata     = 32'h0;
  logic [3:0]  wstrb     = 4'h0;
  logic        wvalid    = 1'b0;
  logic        bready    = 1'b0;
  logic [7:0]  araddr    = 8'h00;
  logic        arvalid   = 1'b0;
  logic        rready    = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, mem_re, mem_we, done;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] mem_addr;
  logic [3:0]  mem_wdata, mem_rdata;
  int          failures     = 0;
  int          total_checks = 0;

  always #4 clk_sys_i = ~clk_sys_i;

  nxs_exec u_nxs_exec (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .mem_addr_o(mem_addr), .mem_re_o(mem_re), .mem_we_o(mem_we), .mem_wdata_o(mem_wdata),
    .mem_rdata_i(mem_rdata), .done_o(done)
  );

  nxs_mem_model u_nxs_mem_model (
    .clk_sys_i(clk_sys_i), .mem_addr_i(mem_addr), .mem_re_i(mem_re),
    .mem_we_i(mem_we), .mem_wdata_i(mem_wdata), .mem_rdata_o(mem_rdata)
  );

  // ==========================================
  // comparisons and closing
  task automatic chk_val(input string what, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : chk_val

  task automatic chk_resp(input string what, input logic [1:0] e, input logic [1:0] g);
    total_checks++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s expected %b seen %b", what, e, g);
    end
  endtask : chk_resp

  task automatic chk_cyc(input string what, input int e, input int g);
    total_checks++;
    if (g != e)
    begin
      failures++;
      $display("BAD %s expected %0d seen %0d", what, e, g);
    end
  endtask : chk_cyc

  task automatic finish_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test

  // ==========================================
  // register bus master
  // ready and valid are flops, so their level at the falling edge is what the next rise sees
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ad;
    logic wd;
    logic [1:0] r;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge clk_sys_i);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= s;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(negedge clk_sys_i);
      if (!ad && awready) ad = 1'b1;
      if (!wd && wready) wd = 1'b1;
      @(posedge clk_sys_i);
      if (ad) awvalid <= 1'b0;
      if (wd) wvalid <= 1'b0;
    end
    while (!(ad && wd));
    do @(negedge clk_sys_i); while (!bvalid);
    r = bresp;
    @(posedge clk_sys_i);
    bready <= 1'b0;
    chk_resp("write response", 2'b00, r);
  endtask : axi_wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er,
                        input string what);
    logic [31:0] d;
    logic [1:0]  r;
    @(posedge clk_sys_i);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(negedge clk_sys_i); while (!arready);
    @(posedge clk_sys_i);
    arvalid <= 1'b0;
    do @(negedge clk_sys_i); while (!rvalid);
    d = rdata;
    r = rresp;
    @(posedge clk_sys_i);
    rready <= 1'b0;
    chk_val(what, e, d);
    chk_resp("read response", er, r);
  endtask : rd_chk

  // ==========================================
  // one instruction: load state, launch, then compare registers, pointers and memory
  task automatic x(input logic [12:0] op, input logic [11:0] dat, input logic [31:0] ptr,
                   input logic [8:0] pfx, input logic [15:0] ma, input logic [3:0] mv,
                   input logic [11:0] edat, input logic [31:0] eptr, input logic [3:0] emv,
                   input int cyc);
    int n;
    u_nxs_mem_model.mem[ma] = mv;
    axi_wr(8'h08, {20'h0, dat}, 4'h3);
    axi_wr(8'h0c, ptr, 4'hf);
    if (pfx[8]) axi_wr(8'h10, {24'h0, pfx[7:0]}, 4'h1);
    axi_wr(8'h00, {19'h0, op}, 4'h1);
    n = 0;
    do
    begin
      @(negedge clk_sys_i);
      n++;
    end
    while (!done && n < 50);
    chk_val("done", 32'h0000_0001, {31'h0, done});
    if (cyc > 0) chk_cyc("cycles", 2 * cyc, n);
    rd_chk(8'h08, {20'h0, edat}, 2'b00, "data");
    rd_chk(8'h0c, eptr, 2'b00, "pointers");
    chk_val("memory", {28'h0, emv}, {28'h0, u_nxs_mem_model.mem[ma]});
  endtask : x

  // ==========================================
  // main sequence
  initial
  begin
    repeat (2) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    rd_chk(8'h08, 32'h0, 2'b00, "data after reset");
    rd_chk(8'h0c, 32'h0, 2'b00, "pointers after reset");
    rd_chk(8'h04, 32'h0, 2'b00, "status after reset");
    rd_chk(8'h20, 32'h0, 2'b10, "unmapped read");
    x(13'h1bf2,12'h635,32'h0,9'h0,16'h0,4'h0,12'h636,32'h0,4'h0,1);
    x(13'h1bf1,12'h639,32'h0,9'h1aa,16'h0,4'h0,12'h730,32'h0,4'h0,1);
    x(13'h1bcc,12'h073,32'h0,9'h0,16'h0,4'h0,12'h07f,32'h0,4'h0,0);
    x(13'h1bd7,12'h073,32'h0,9'h155,16'h0,4'h0,12'h103,32'h0,4'h0,0);
    for (int i = 0; i < 16; i++)
      x(13'h10a0 | 13'(i),12'h600,32'h0,9'h0,16'h0,4'h0,{4'h6 ^ 4'(i),8'h00},32'h0,4'h0,1);
    x(13'h1be0,12'h005,32'h1234,9'h134,16'h0034,4'ha,12'h00f,32'h1234,4'ha,0);
    x(13'h1be6,12'h030,32'h56780000,9'h134,16'hff34,4'h3,12'h100,32'h56780000,4'h3,0);
    x(13'h1be1,12'h606,32'hffff,9'h134,16'hffff,4'h6,12'h700,32'h0,4'h6,1);
    x(13'h1be7,12'h020,32'h00ff0000,9'h0,16'h00ff,4'h1,12'h030,32'h01000000,4'h1,1);
    x(13'h1be8,12'h005,32'h0040,9'h0,16'h0040,4'hc,12'h005,32'h0040,4'h9,0);
    x(13'h1bee,12'h040,32'h11110000,9'h180,16'hff80,4'h4,12'h140,32'h11110000,4'h0,0);
    x(13'h1be9,12'h003,32'h0050,9'h177,16'h0050,4'h3,12'h103,32'h0051,4'h0,2);
    x(13'h1bef,12'h080,32'hffff0000,9'h0,16'hffff,4'h1,12'h080,32'h0,4'h9,2);
    x(13'h1b85,12'h000,32'h2222,9'h120,16'h0020,4'ha,12'h000,32'h2222,4'hf,2);
    x(13'h1ba3,12'h600,32'h03000000,9'h0,16'h0300,4'h3,12'h700,32'h03000000,4'h0,2);
    x(13'h1b9f,12'h000,32'h0010,9'h0,16'h0010,4'hf,12'h100,32'h0011,4'h0,2);
    x(13'h1bb1,12'h000,32'h00200000,9'h0,16'h0020,4'h4,12'h000,32'h00210000,4'h5,2);
    x(13'h1813,12'h400,32'h0030,9'h130,16'h0030,4'h1,12'h600,32'h0031,4'he,2);
    x(13'h1835,12'h000,32'hffff0000,9'h0,16'hffff,4'h5,12'h100,32'h0,4'h0,2);
    x(13'h1295,12'h100,32'h0,9'h1ff,16'h0015,4'h4,12'h000,32'h0,4'h4,1);
    x(13'h13fe,12'h000,32'h0,9'h0,16'hfffe,4'h7,12'h100,32'h0,4'h7,1);
    // an undecoded opcode must not start anything but is flagged in status
    axi_wr(8'h00, 32'h0000_1fff, 4'h1);
    rd_chk(8'h04, 32'h0000_0002, 2'b00, "status undecoded");
    rd_chk(8'h00, 32'h0000_1fff, 2'b00, "last opcode");
    rd_chk(8'h10, 32'h0000_00ff, 2'b00, "prefix");
    finish_test();
  end

  // ==========================================
  // watchdog, well beyond the roughly eight hundred clocks the sequence needs
  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    failures++;
    $display("BAD watchdog expected end seen hang");
    finish_test();
  end
endmodule : nxs_exec_test
